/* design/amp_fault_defs.vh */
// Purpose: Shared constants for the amplifier fault protection manager
// Assumes: 25 MHz core clock, 8-bit register port, 4-bit register address
// Notes:   DC time is given in ms and its cycle count derives from it; the fault timeout is given in cycles
`ifndef AMP_FAULT_DEFS_VH
`define AMP_FAULT_DEFS_VH

`define CLK_KHZ            25000
`define DC_DETECT_MS       420
`define DC_DETECT_CYCLES   (`DC_DETECT_MS * `CLK_KHZ)
`define FAULT_TIMEOUT_CYCLES 1000

`define ADDR_W             4
`define DATA_W             8
`define REG_CTRL           4'h0
`define REG_STATUS         4'h1

`define CTRL_SD_BIT        0
`define CTRL_RATE_LSB      1
`define CTRL_RATE_MSB      2
`define CTRL_RESET         8'h01

`define ST_OVE             0
`define ST_UVE             1
`define ST_CLOCKING_ERR            2
`define ST_OCE             3
`define ST_DCE             4
`define ST_OTE             5
`define ST_PLAY            6
`define ST_LINE            7

`define RATE_SHIFT_BASE    3

`endif

/* design/pwm_channel.v */
// Purpose: One channel of the digital-to-PWM stage, complementary outputs
// Assumes: Sample is two's complement, period in core clock cycles
// Notes:   Threshold is taken once per frame so the duty stays glitch free
`timescale 1ns/100ps
`default_nettype none

module pwm_channel #(
   parameter SW = 16,
   parameter CW = 12
) (
   input  wire          clk,
   input  wire          reset,
   input  wire          clk_en,
   input  wire          enable,
   input  wire          frame_start,
   input  wire [SW-1:0] sample,
   input  wire [CW-1:0] period,
   output reg           out_p,
   output reg           out_n
);

   reg  [CW-1:0]    cnt_q;
   reg  [CW-1:0]    thr_q;
   wire [SW-1:0]    ofs;
   wire [SW+CW-1:0] prod;
   wire [CW:0]      cnt_inc;
   wire             high;

   // Offset binary so zero input gives half duty
   assign ofs     = {~sample[SW-1], sample[SW-2:0]};
   assign prod    = ofs * period;
   assign cnt_inc = {1'b0, cnt_q} + {{CW{1'b0}}, 1'b1};
   assign high    = cnt_q < thr_q;

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_q <= {CW{1'b0}};
         thr_q <= {CW{1'b0}};
         out_p <= 1'b0;
         out_n <= 1'b0;
      end else if (clk_en) begin
         if (frame_start) begin
            cnt_q <= {CW{1'b0}};
            thr_q <= prod[SW+CW-1:SW];
         end else if (cnt_inc >= {1'b0, period}) begin
            cnt_q <= {CW{1'b0}};
         end else begin
            cnt_q <= cnt_inc[CW-1:0];
         end
         // Both legs low when stopped, never both high
         out_p <= enable & high;
         out_n <= enable & ~high;
      end
   end

endmodule // pwm_channel

`default_nettype wire

/* design/amp_fault_protection_manager.v */
// Purpose: Fault sorting, fault line, recovery and PWM stage of the amplifier
// Assumes: All detector flags and pins are synchronous to clk
// Notes:   Register port is 8 bits wide, read data valid one cycle after
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "amp_fault_defs.vh"

module amp_fault_protection_manager #(
   parameter [23:0] DC_CYCLES      = `DC_DETECT_CYCLES,
   parameter [23:0] TIMEOUT_CYCLES = `FAULT_TIMEOUT_CYCLES,
   parameter        SW             = 16,
   parameter        CW             = 12
) (
   input  wire              clk,
   input  wire              reset,
   input  wire              clk_en,
   input  wire [`ADDR_W-1:0] reg_addr,
   input  wire [`DATA_W-1:0] reg_wdata,
   input  wire              reg_write,
   input  wire              reg_read,
   output reg  [`DATA_W-1:0] reg_rdata,
   input  wire              amp_shutdown_n,
   input  wire              amp_fault_n_level,
   output reg               amp_fault_n,
   output reg               amp_fault_n_oe,
   input  wire              supply_overvoltage_err,
   input  wire              supply_undervoltage_err,
   input  wire              output_overcurrent_err,
   input  wire              die_overtemp_err,
   input  wire              overtemp_hysteresis_level,
   input  wire              mclk_ratio_bad,
   input  wire              sclk_ratio_bad,
   input  wire              mclk_rate_bad,
   input  wire              lrck_rate_bad,
   input  wire              mclk_stopped,
   input  wire              sclk_stopped,
   input  wire              lrck_stopped,
   input  wire              duty_over_l,
   input  wire              duty_pol_l,
   input  wire              duty_over_r,
   input  wire              duty_pol_r,
   input  wire              hw_mode,
   input  wire [1:0]        hw_rate_sel,
   input  wire              sample_strobe,
   input  wire [SW-1:0]     left_sample,
   input  wire [SW-1:0]     right_sample,
   output wire              pwm_l_p,
   output wire              pwm_l_n,
   output wire              pwm_r_p,
   output wire              pwm_r_n,
   output reg               playing
);

   localparam [3:0] S_RUN   = 4'b0001;
   localparam [3:0] S_FAULT = 4'b0010;
   localparam [3:0] S_SHDN  = 4'b0100;
   localparam [3:0] S_WAIT  = 4'b1000;

   reg  [3:0]         state_q;
   reg  [3:0]         state_d;
   reg  [`DATA_W-1:0] ctrl_q;
   reg  [2:0]         lat_q;
   reg  [2:0]         lat_d;
   reg  [2:0]         nl_q;
   reg                sd_eff_q;
   reg  [23:0]        tmo_q;
   reg  [23:0]        tmo_d;
   reg  [23:0]        dc_l_q;
   reg  [23:0]        dc_r_q;
   reg                pol_l_q;
   reg                pol_r_q;
   reg  [CW-1:0]      frame_cnt_q;
   reg  [CW-1:0]      frame_len_q;

   wire               sd_eff;
   wire               sd_rise;
   wire               sd_fall;
   wire               clk_err;
   wire               dce_det;
   wire               ote_now;
   wire [2:0]         err_now;
   wire [2:0]         set_lat;
   wire               run_ok;
   wire [1:0]         rate_sel;
   wire [CW-1:0]      pwm_period;

   // Pin and register bit both gate shutdown; either one low stops play
   assign sd_eff  = amp_shutdown_n & ctrl_q[`CTRL_SD_BIT];
   assign sd_rise = sd_eff & ~sd_eff_q;
   assign sd_fall = ~sd_eff & sd_eff_q;

   assign clk_err = mclk_ratio_bad | sclk_ratio_bad | mclk_rate_bad |
                    lrck_rate_bad | mclk_stopped | sclk_stopped |
                    lrck_stopped;

   function [23:0] dc_next;
      input [23:0] cnt;
      input        over;
      input        pol;
      input        last_pol;
      input [23:0] lim;
      begin
         if (!over || (pol != last_pol)) begin
            dc_next = 24'h000000;
         end else if (cnt < lim) begin
            dc_next = cnt + 24'h000001;
         end else begin
            dc_next = cnt;
         end
      end
   endfunction

   // Count reaches the limit only after the full window of overrun at one polarity
   assign dce_det = (dc_l_q == DC_CYCLES) | (dc_r_q == DC_CYCLES);

   // Latched overtemp stays present until below hysteresis level
   assign ote_now = die_overtemp_err |
                    (lat_q[2] & overtemp_hysteresis_level);
   assign err_now = {ote_now, dce_det, output_overcurrent_err};
   assign set_lat = err_now & {3{sd_eff}};

   // Supply faults only stop playback, no fault line, no latch
   assign run_ok = ~supply_overvoltage_err & ~supply_undervoltage_err &
                   ~clk_err;

   always @* begin
      state_d = state_q;
      tmo_d   = tmo_q;
      lat_d   = lat_q | set_lat;
      case (state_q)
         S_RUN: begin
            if (|set_lat) begin
               state_d = S_FAULT;
            end else if (!sd_eff) begin
               state_d = S_SHDN;
            end
         end
         S_FAULT: begin
            if (!sd_eff) begin
               state_d = S_SHDN;
            end
         end
         S_SHDN: begin
            if (sd_rise) begin
               if (|err_now) begin
                  state_d = S_FAULT;
               end else if (|lat_q) begin
                  state_d = S_WAIT;
                  tmo_d   = TIMEOUT_CYCLES;
               end else begin
                  state_d = S_RUN;
               end
            end
         end
         S_WAIT: begin
            if (|set_lat) begin
               state_d = S_FAULT;
            end else if (sd_fall) begin
               state_d = S_SHDN;
            end else if (tmo_q == 24'h000000) begin
               // Fresh sets still win over this clear
               state_d = S_RUN;
               lat_d   = set_lat;
            end else begin
               tmo_d = tmo_q - 24'h000001;
            end
         end
         default: begin
            state_d = S_FAULT;
         end
      endcase
   end

   assign rate_sel   = hw_mode ? hw_rate_sel :
                       ctrl_q[`CTRL_RATE_MSB:`CTRL_RATE_LSB];
   // Switching period is frame length over 8, 16, 32 or 64
   assign pwm_period = frame_len_q >> (rate_sel + `RATE_SHIFT_BASE);

   // Saturating step, so a lost strobe cannot wrap the frame measure
   function [CW-1:0] sat_inc;
      input [CW-1:0] val;
      begin
         if (&val) begin
            sat_inc = val;
         end else begin
            sat_inc = val + {{(CW-1){1'b0}}, 1'b1};
         end
      end
   endfunction

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q     <= S_SHDN;
         ctrl_q      <= `CTRL_RESET;
         lat_q       <= 3'b000;
         nl_q        <= 3'b000;
         sd_eff_q    <= 1'b0;
         tmo_q       <= 24'h000000;
         dc_l_q      <= 24'h000000;
         dc_r_q      <= 24'h000000;
         pol_l_q     <= 1'b0;
         pol_r_q     <= 1'b0;
         frame_cnt_q <= {CW{1'b0}};
         frame_len_q <= {CW{1'b0}};
         reg_rdata   <= 8'h00;
         amp_fault_n    <= 1'b0;
         amp_fault_n_oe <= 1'b0;
         playing     <= 1'b0;
      end else if (clk_en) begin
         state_q  <= state_d;
         lat_q    <= lat_d;
         tmo_q    <= tmo_d;
         sd_eff_q <= sd_eff;
         nl_q     <= {clk_err, supply_undervoltage_err,
                      supply_overvoltage_err};
         dc_l_q   <= dc_next(dc_l_q, duty_over_l, duty_pol_l, pol_l_q,
                             DC_CYCLES);
         dc_r_q   <= dc_next(dc_r_q, duty_over_r, duty_pol_r, pol_r_q,
                             DC_CYCLES);
         pol_l_q  <= duty_pol_l;
         pol_r_q  <= duty_pol_r;
         // Frame length measured between sample strobes, saturating
         // Strobe cycle counted too, so the multiple of fs stays exact
         if (sample_strobe) begin
            frame_len_q <= sat_inc(frame_cnt_q);
            frame_cnt_q <= {CW{1'b0}};
         end else begin
            frame_cnt_q <= sat_inc(frame_cnt_q);
         end
         if (reg_write && (reg_addr == `REG_CTRL)) begin
            ctrl_q <= reg_wdata;
         end
         reg_rdata <= 8'h00;
         if (reg_read) begin
            case (reg_addr)
               `REG_CTRL: begin
                  reg_rdata <= ctrl_q;
               end
               `REG_STATUS: begin
                  reg_rdata <= {amp_fault_n_level, playing, lat_q,
                                nl_q};
               end
               default: begin
                  reg_rdata <= 8'h00;
               end
            endcase
         end
         // Drive value fixed low; only the enable moves the line
         amp_fault_n    <= 1'b0;
         // Latch held until recovery; clock error follows its flag
         amp_fault_n_oe <= (|lat_d) | clk_err;
         playing        <= (state_d == S_RUN) & run_ok;
      end
   end

   pwm_channel #(
      .SW (SW),
      .CW (CW)
   ) u_pwm_l (
      .clk         (clk),
      .reset       (reset),
      .clk_en      (clk_en),
      .enable      (playing),
      .frame_start (sample_strobe),
      .sample      (left_sample),
      .period      (pwm_period),
      .out_p       (pwm_l_p),
      .out_n       (pwm_l_n)
   );

   pwm_channel #(
      .SW (SW),
      .CW (CW)
   ) u_pwm_r (
      .clk         (clk),
      .reset       (reset),
      .clk_en      (clk_en),
      .enable      (playing),
      .frame_start (sample_strobe),
      .sample      (right_sample),
      .period      (pwm_period),
      .out_p       (pwm_r_p),
      .out_n       (pwm_r_n)
   );

endmodule // amp_fault_protection_manager

`default_nettype wire

/* dv/amp_fault_properties.sv */
// Purpose: Port assertions of the fault manager
// Assumes: Single clock domain, clk_en gates every check
// Notes:   Recovery time is bounded from below only
`timescale 1ns/100ps
`default_nettype none
module amp_fault_checker #(
   parameter [23:0] TIMEOUT_CYCLES = 24'h0003E8
) (
   input wire logic       clk,
   input wire logic       reset,
   input wire logic       clk_en,
   input wire logic [3:0] reg_addr,
   input wire logic       reg_write,
   input wire logic       reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic       amp_shutdown_n,
   input wire logic       amp_fault_n_level,
   input wire logic       amp_fault_n,
   input wire logic       amp_fault_n_oe,
   input wire logic       supply_overvoltage_err,
   input wire logic       supply_undervoltage_err,
   input wire logic       output_overcurrent_err,
   input wire logic       die_overtemp_err,
   input wire logic       overtemp_hysteresis_level,
   input wire logic       mclk_ratio_bad,
   input wire logic       sclk_ratio_bad,
   input wire logic       mclk_rate_bad,
   input wire logic       lrck_rate_bad,
   input wire logic       mclk_stopped,
   input wire logic       sclk_stopped,
   input wire logic       lrck_stopped,
   input wire logic       duty_over_l,
   input wire logic       duty_over_r,
   input wire logic       pwm_l_p,
   input wire logic       pwm_l_n,
   input wire logic       pwm_r_p,
   input wire logic       pwm_r_n,
   input wire logic       playing
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset || !clk_en);
   wire ck = mclk_ratio_bad | sclk_ratio_bad | mclk_rate_bad | lrck_rate_bad
      | mclk_stopped | sclk_stopped | lrck_stopped;
   wire lat = output_overcurrent_err | die_overtemp_err;
   wire any_err = ck | lat | overtemp_hysteresis_level | duty_over_l
      | duty_over_r;
   reg  [23:0] since_q;
   // A CTRL write may toggle the shutdown bit, so it may start the count
   always @(posedge clk or posedge reset) begin
      if (reset)
         since_q <= 24'h000000;
      else if ($rose(amp_shutdown_n) || (reg_write && since_q == 24'h0))
         since_q <= 24'h000001;
      else if (!amp_shutdown_n || $rose(amp_fault_n_oe))
         since_q <= 24'h000000;
      else if (since_q != 24'h000000)
         since_q <= since_q + 24'h000001;
   end
   property p_drive;
      amp_fault_n_oe |-> !amp_fault_n;
   endproperty
   a_drive: assert property (p_drive) else $error("fault line high");
   property p_latch;
      lat && playing && amp_shutdown_n |=> amp_fault_n_oe && !playing;
   endproperty
   a_latch: assert property (p_latch) else $error("latch missed");
   property p_clk;
      ck && playing |=> amp_fault_n_oe && !playing;
   endproperty
   a_clk: assert property (p_clk) else $error("clock fault missed");
   property p_nofault;
      playing |-> !amp_fault_n_oe;
   endproperty
   a_nofault: assert property (p_nofault) else $error("fault in play");
   property p_quiet;
      (supply_overvoltage_err || supply_undervoltage_err) && !amp_fault_n_oe
         && !any_err && !$past(any_err) |=> !amp_fault_n_oe;
   endproperty
   a_quiet: assert property (p_quiet) else $error("supply drove fault");
   property p_recover;
      $fell(amp_fault_n_oe) && !$past(ck) && !$past(ck, 2)
         |-> since_q >= TIMEOUT_CYCLES;
   endproperty
   a_recover: assert property (p_recover) else $error("early release");
   property p_status;
      $past(reg_read) && $past(reg_addr) == 4'h1
         |-> reg_rdata[7:6] == {$past(amp_fault_n_level), $past(playing)};
   endproperty
   a_status: assert property (p_status) else $error("status wrong");
   property p_pwm;
      playing && $past(playing) && $past(playing, 2)
         |-> (pwm_l_p ^ pwm_l_n) && (pwm_r_p ^ pwm_r_n);
   endproperty
   a_pwm: assert property (p_pwm) else $error("pwm not paired");
   c_fault: cover property ($rose(amp_fault_n_oe));
   c_back: cover property ($fell(amp_fault_n_oe) && since_q != 24'h0);
   c_play: cover property ($rose(playing));
endmodule // amp_fault_checker
bind amp_fault_protection_manager amp_fault_checker #(
   .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (.*);
`default_nettype wire

/* dv/sys_controller.sv */
// Purpose: System controller watching the fault wire, driving shutdown
// Assumes: Fault wire has a pull-up outside the device
// Notes:   No fault-to-shutdown loop, it would hold shutdown low for good
`timescale 1ns/100ps
`default_nettype none
module sys_controller (
   input  wire logic clk,
   input  wire logic sd_on,
   input  wire logic amp_fault_n,
   input  wire logic amp_fault_n_oe,
   output var  logic amp_shutdown_n,
   output wire logic amp_fault_n_level
);
   assign amp_fault_n_level = amp_fault_n_oe ? amp_fault_n : 1'b1;
   initial amp_shutdown_n = 1'b1;
   always @(posedge clk) begin
      amp_shutdown_n <= sd_on;
   end
endmodule // sys_controller
`default_nettype wire

/* dv/amp_fault_protection_manager_tb.sv */
// Purpose: Directed tests of fault sorting, recovery and PWM rate
// Assumes: Short DC and timeout counts for simulation
// Notes:   Recovery figures carry a few cycles of slack
`timescale 1ns/100ps
`default_nettype none
module amp_fault_protection_manager_tb;
   localparam int T = 8;
   localparam int DC = 20;
   logic       clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, fc = 8'h00;
   logic [6:0] ck = 7'h00;
   logic [2:0] lat = 3'h0, dt = 3'h0;
   logic       ce = 1'b1, hy = 1'b0;
   logic [1:0] sv = 2'h0, hw_rate_sel = 2'h0;
   logic       sd_on = 1'b1, hw_mode = 1'b1, amp_shutdown_n, amp_fault_n_level;
   logic       amp_fault_n, amp_fault_n_oe, playing;
   logic       pwm_l_p, pwm_l_n, pwm_r_p, pwm_r_n;
   int         err_count = 0, compares = 0, n, e, pc;
   always #20 clk = ~clk;
   always @(posedge clk) fc <= fc + 8'h01;
   always @(posedge pwm_l_p) pc++;
   amp_fault_protection_manager #(.DC_CYCLES(DC), .TIMEOUT_CYCLES(T)) uut (
      .clk, .reset, .clk_en(ce), .reg_addr, .reg_wdata, .reg_write,
      .reg_read, .reg_rdata, .amp_shutdown_n, .amp_fault_n_level,
      .amp_fault_n, .amp_fault_n_oe, .supply_overvoltage_err(sv[0]),
      .supply_undervoltage_err(sv[1]), .output_overcurrent_err(lat[0]),
      .die_overtemp_err(lat[2]), .overtemp_hysteresis_level(hy),
      .mclk_ratio_bad(ck[0]), .sclk_ratio_bad(ck[1]), .mclk_rate_bad(ck[2]),
      .lrck_rate_bad(ck[3]), .mclk_stopped(ck[4]), .sclk_stopped(ck[5]),
      .lrck_stopped(ck[6]), .duty_over_l(lat[1] | dt[0]),
      .duty_pol_l(dt[1]), .duty_over_r(dt[2]), .duty_pol_r(1'b0),
      .hw_mode, .hw_rate_sel,
      .sample_strobe(fc == 8'h00), .left_sample(16'h0000),
      .right_sample({fc, fc}), .pwm_l_p, .pwm_l_n, .pwm_r_p, .pwm_r_n,
      .playing);
   sys_controller ctl (.clk, .sd_on, .amp_fault_n, .amp_fault_n_oe,
      .amp_shutdown_n, .amp_fault_n_level);
   task chk(input string s, input logic [7:0] x, input logic [7:0] v);
      compares++;
      if (v !== x) begin
         err_count++;
         $display("Error %s expected %h seen %h", s, x, v);
      end
   endtask
   task w(input int k);
      repeat (k) @(negedge clk);
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task rd(input string s, input logic [3:0] a, input logic [7:0] x);
      @(posedge clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'b0;
      @(negedge clk);
      chk(s, x, reg_rdata);
   endtask
   // Shutdown low for one cycle, then count cycles until the line lets go
   task tog;
      @(posedge clk) sd_on <= 1'b0;
      @(posedge clk) sd_on <= 1'b1;
      n = 0;
      while (amp_fault_n_oe === 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
   endtask
   task complete_run;
      $display("Checks %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      w(3);
      chk("run_after_reset", 8'h01, {amp_fault_n_oe, playing});
      rd("ctrl_reset", 4'h0, 8'h01);
      wr(4'h5, 8'hFF);
      rd("unmapped", 4'h5, 8'h00);
      wr(4'h0, 8'hA7);
      rd("ctrl_rw", 4'h0, 8'hA7);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk) lat <= 3'h1 << i;
         hy <= (i == 2);
         w(i == 1 ? DC + 4 : 2);
         chk("latch", 8'h02, {amp_fault_n_oe, playing});
         rd("latch_status", 4'h1, 8'h08 << i);
         if (i != 1) begin
            tog;
            chk("refault", 8'h02, {amp_fault_n_oe, playing});
         end
         @(posedge clk) lat <= 3'h0;
         if (i == 2) begin
            // Below trip but above hysteresis still counts as present
            tog;
            chk("hyst_refault", 8'h02, {amp_fault_n_oe, playing});
            @(posedge clk) hy <= 1'b0;
         end
         w(20);
         chk("hold", 8'h02, {amp_fault_n_oe, playing});
         tog;
         chk("recovery", 8'h01, {7'h00, n > T && n < T + 9});
         w(2);
         rd("resumed", 4'h1, 8'hC0);
      end
      for (int j = 0; j < 7; j++) begin
         @(posedge clk) ck <= 7'h01 << j;
         w(3);
         rd("clock_err", 4'h1, 8'h04);
         @(posedge clk) ck <= 7'h00;
         w(3);
         chk("clock_release", 8'h01, {amp_fault_n_oe, playing});
      end
      for (int k = 0; k < 2; k++) begin
         @(posedge clk) sv <= 2'h1 << k;
         w(3);
         rd("supply_err", 4'h1, 8'h80 | (8'h01 << k));
         @(posedge clk) sv <= 2'h0;
         w(3);
         chk("supply_release", 8'h01, {amp_fault_n_oe, playing});
      end
      // Enable low must hold every flop, a clock error included
      @(posedge clk) ce <= 1'b0;
      ck <= 7'h01;
      w(3);
      chk("freeze", 8'h01, {amp_fault_n_oe, playing});
      @(posedge clk) ce <= 1'b1;
      ck <= 7'h00;
      w(3);
      chk("thaw", 8'h01, {amp_fault_n_oe, playing});
      // Polarity flips inside the window, so no DC error builds up
      @(posedge clk) dt <= 3'b011;
      repeat (6) begin
         w(DC / 2);
         @(posedge clk) dt[1] <= ~dt[1];
      end
      chk("dc_polarity", 8'h01, {amp_fault_n_oe, playing});
      @(posedge clk) dt <= 3'b100;
      w(DC + 4);
      rd("dc_right", 4'h1, 8'h10);
      @(posedge clk) dt <= 3'b000;
      tog;
      chk("dc_right_rec", 8'h01, {7'h00, n > T && n < T + 9});
      // Pins and CTRL ask for different rates, only the selected one counts
      for (int m = 0; m < 8; m++) begin
         @(posedge clk) hw_mode <= (m < 4);
         hw_rate_sel <= m[1:0];
         wr(4'h0, {5'h00, ~m[1:0], 1'b1});
         e = 8 << ((m < 4) ? m[1:0] : ~m[1:0]);
         w(600);
         pc = 0;
         w(256);
         chk("pwm_rate", e[7:0], pc[7:0]);
      end
      complete_run;
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      complete_run;
   end
endmodule // amp_fault_protection_manager_tb
`default_nettype wire
